// ### hw/gie_pkg.sv
// Package with shared constants and types for the branch and increment execution unit.
package gie_pkg;

	// Register bus byte offsets.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_BANK   = 8'h04;
	localparam logic [7:0] OFS_WORK   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PC     = 8'h10;
	localparam logic [7:0] OFS_INDEX  = 8'h14;

	// Control register fields.
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EXT_BIT = 1;

	// Status flag positions.
	localparam int ST_C  = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z  = 2;
	localparam int ST_OV = 3;
	localparam int ST_N  = 4;

	// Reset values.
	localparam logic [20:0] PC_RST     = 21'h0_0000;
	localparam logic [7:0]  WORK_RST   = 8'h00;
	localparam logic [4:0]  STATUS_RST = 5'h00;
	localparam logic [3:0]  BANK_RST   = 4'h0;
	localparam logic [11:0] INDEX_RST  = 12'h000;
	localparam logic [1:0]  CTRL_RST   = 2'h0;

	// Encodings.
	localparam logic [7:0]  BRANCH_W1_HI = 8'hEF;
	localparam logic [3:0]  BRANCH_W2_HI = 4'hF;
	localparam logic [5:0]  INC_OPCODE   = 6'h0A;
	localparam logic [15:0] NOP_WORD     = 16'h0000;
	localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
	localparam logic [7:0]  INDEX_LIMIT  = 8'h5F;
	localparam logic [3:0]  ACCESS_HI    = 4'hF;
	localparam logic [20:0] PC_STEP      = 21'h0_0002;

	typedef enum logic [1:0] {GIE_OP_NOP, GIE_OP_BRANCH, GIE_OP_INC} gie_op_e;

	// One clock per phase; four phases per instruction cycle.
	typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} gie_phase_e;

	typedef struct packed {
		gie_phase_e  ph;
		logic        ph_first;
		logic        flush;
		logic [15:0] ir;
		logic [7:0]  lit_lo;
		logic [20:0] pc;
		logic [7:0]  work;
		logic [4:0]  status;
		logic [7:0]  res;
		logic [4:0]  flg;
		logic [3:0]  bank;
		logic [11:0] index;
		logic        run;
		logic        ext;
		logic [11:0] daddr;
		logic        dwe;
		logic [7:0]  dwdat;
		logic        ack;
		logic [31:0] rdat;
	} gie_state_s;

endpackage

// ### hw/gie_core_if.sv
// Interface joining the core to its decoder and its incrementer.
`timescale 1ns/1ps
interface gie_core_if;
	logic [15:0]          ir;
	gie_pkg::gie_op_e     op;
	logic                 dst_f;
	logic                 bank_sel;
	logic [7:0]           faddr;
	logic [7:0]           operand;
	logic [7:0]           sum;
	logic [4:0]           flags;

	modport dec  (input ir, output op, dst_f, bank_sel, faddr);
	modport alu  (input operand, output sum, flags);
	modport core (output ir, operand, input op, dst_f, bank_sel, faddr, sum, flags);
endinterface

// ### hw/gie_decode.sv
// Instruction word decoder for the branch and increment instructions.
`timescale 1ns/1ps
module gie_decode (
	// Decode channel
	gie_core_if.dec dif
);
	always_comb begin
		dif.op       = gie_pkg::GIE_OP_NOP;
		dif.dst_f    = dif.ir[9];
		dif.bank_sel = dif.ir[8];
		dif.faddr    = dif.ir[7:0];
		if (dif.ir[15:8] == gie_pkg::BRANCH_W1_HI) begin
			dif.op = gie_pkg::GIE_OP_BRANCH;
		end else if (dif.ir[15:10] == gie_pkg::INC_OPCODE) begin
			dif.op = gie_pkg::GIE_OP_INC;
		end
	end
endmodule

// ### hw/gie_inc_alu.sv
// Byte incrementer with its status flags.
`timescale 1ns/1ps
module gie_inc_alu (
	// Arithmetic channel
	gie_core_if.alu aif
);
	logic [8:0] wide;
	logic [4:0] low;

	always_comb begin
		wide     = {1'b0, aif.operand} + 9'h001;
		low      = {1'b0, aif.operand[3:0]} + 5'h01;
		aif.sum  = wide[7:0];
		aif.flags = '0;
		// Adding one overflows only when the operand is the largest positive byte.
		aif.flags[gie_pkg::ST_C]  = wide[8];
		aif.flags[gie_pkg::ST_DC] = low[4];
		aif.flags[gie_pkg::ST_Z]  = (wide[7:0] == 8'h00);
		aif.flags[gie_pkg::ST_OV] = ~aif.operand[7] & wide[7];
		aif.flags[gie_pkg::ST_N]  = wide[7];
	end
endmodule

// ### hw/gie_exec.sv
// Execution unit for the absolute branch and register increment instructions, with a Wishbone register slave.
`timescale 1ns/1ps
// Behaviour
// - Branch loads literal into pc bits 20:1.
// - Branch literal covers full twenty bit range.
// - First branch word upper byte is EF.
// - Second word starts 1111, holds literal 19:8.
// - Branch takes two cycles, second is empty.
// - Increment adds one to the addressed register.
// - Increment updates carry, nibble, negative, overflow, zero.
// - Destination bit zero writes working register only.
// - Destination bit one writes back to register.
// - Bank bit zero uses the fixed access bank.
// - Bank bit one combines bank register and address.
// - Extended set, low address: indexed offset addressing.
module gie_exec (
	// Clock and reset
	input  wire  logic        ref_clk,
	input  wire  logic        reset,
	// Wishbone slave
	input  wire  logic        wb_cyc_i,
	input  wire  logic        wb_stb_i,
	input  wire  logic        wb_we_i,
	input  wire  logic [7:0]  wb_adr_i,
	input  wire  logic [3:0]  wb_sel_i,
	input  wire  logic [31:0] wb_dat_i,
	output logic       [31:0] wb_dat_o,
	output logic              wb_ack_o,
	// Program memory fetch
	output logic       [20:0] prog_addr,
	input  wire  logic [15:0] prog_data,
	// Data register file
	output logic       [11:0] data_addr,
	input  wire  logic [7:0]  data_rd_data,
	output logic              data_we,
	output logic       [7:0]  data_wr_data,
	// Core state
	output logic       [7:0]  work_reg_o,
	output logic       [4:0]  status_o,
	output logic              phase_start
);
	gie_pkg::gie_state_s st_reg;
	gie_pkg::gie_state_s st_next;
	gie_core_if          cif ();

	gie_decode u_decode (
		.dif (cif.dec)
	);

	gie_inc_alu u_alu (
		.aif (cif.alu)
	);

	assign cif.ir      = st_reg.ir;
	assign cif.operand = data_rd_data;

	// Resolves the 8-bit register address into a 12-bit data address.
	function automatic logic [11:0] resolve_addr(input logic bank_sel, input logic ext, input logic [7:0] f,
	                                             input logic [3:0] bank, input logic [11:0] index);
		logic [11:0] a;
		a = {bank, f};
		if (!bank_sel) begin
			if (ext && f <= gie_pkg::INDEX_LIMIT) begin
				a = index + {4'h0, f};
			end else if (f < gie_pkg::ACCESS_SPLIT) begin
				a = {4'h0, f};
			end else begin
				a = {gie_pkg::ACCESS_HI, f};
			end
		end
		return a;
	endfunction

	// Merges a write into a register under the byte lane enables.
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic        bus_req;
	logic        bus_wr;
	logic [31:0] ctrl_word;
	logic [31:0] wmerge;

	always_comb begin
		st_next   = st_reg;
		bus_req   = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack;
		ctrl_word = {30'h0, st_reg.ext, st_reg.run};
		wmerge    = 32'h0000_0000;

		// Register slave: one wait state, ack drops the cycle after it is given.
		st_next.ack = bus_req;
		if (bus_req) begin
			case (wb_adr_i)
				gie_pkg::OFS_CTRL:   st_next.rdat = ctrl_word;
				gie_pkg::OFS_BANK:   st_next.rdat = {28'h000_0000, st_reg.bank};
				gie_pkg::OFS_WORK:   st_next.rdat = {24'h00_0000, st_reg.work};
				gie_pkg::OFS_STATUS: st_next.rdat = {27'h000_0000, st_reg.status};
				gie_pkg::OFS_PC:     st_next.rdat = {11'h000, st_reg.pc};
				gie_pkg::OFS_INDEX:  st_next.rdat = {20'h0_0000, st_reg.index};
				default:             st_next.rdat = 32'h0000_0000;
			endcase
		end
		// A write lands at the edge where the master sees ack, so it meets the read data hand-over edge.
		if (bus_wr) begin
			case (wb_adr_i)
				gie_pkg::OFS_CTRL: begin
					wmerge      = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
					st_next.run = wmerge[gie_pkg::CTRL_RUN_BIT];
					st_next.ext = wmerge[gie_pkg::CTRL_EXT_BIT];
				end
				gie_pkg::OFS_BANK: begin
					wmerge       = lane_merge({28'h000_0000, st_reg.bank}, wb_dat_i, wb_sel_i);
					st_next.bank = wmerge[3:0];
				end
				gie_pkg::OFS_INDEX: begin
					wmerge        = lane_merge({20'h0_0000, st_reg.index}, wb_dat_i, wb_sel_i);
					st_next.index = wmerge[11:0];
				end
				default: begin
				end
			endcase
		end

		// Instruction phases. A stopped core parks in the decode phase without fetching.
		case (st_reg.ph)
			gie_pkg::PH_DECODE: begin
				if (st_reg.run) begin
					st_next.ph = gie_pkg::PH_READ;
					if (st_reg.flush) begin
						st_next.ir = gie_pkg::NOP_WORD;
					end else begin
						st_next.ir = prog_data;
						st_next.pc = st_reg.pc + gie_pkg::PC_STEP;
					end
				end
			end
			gie_pkg::PH_READ: begin
				st_next.ph = gie_pkg::PH_PROCESS;
				if (cif.op == gie_pkg::GIE_OP_BRANCH) begin
					st_next.lit_lo = st_reg.ir[7:0];
				end
				if (cif.op == gie_pkg::GIE_OP_INC) begin
					st_next.daddr = resolve_addr(cif.bank_sel, st_reg.ext, cif.faddr, st_reg.bank,
					                             st_reg.index);
				end
			end
			gie_pkg::PH_PROCESS: begin
				st_next.ph = gie_pkg::PH_WRITE;
				if (cif.op == gie_pkg::GIE_OP_INC) begin
					st_next.res   = cif.sum;
					st_next.flg   = cif.flags;
					st_next.dwe   = cif.dst_f;
					st_next.dwdat = cif.sum;
				end
			end
			gie_pkg::PH_WRITE: begin
				st_next.ph    = gie_pkg::PH_DECODE;
				st_next.dwe   = 1'b0;
				st_next.flush = 1'b0;
				// The second word is the word now fetched at the advanced program counter.
				if (cif.op == gie_pkg::GIE_OP_BRANCH && prog_data[15:12] == gie_pkg::BRANCH_W2_HI) begin
					st_next.pc    = {prog_data[11:0], st_reg.lit_lo, 1'b0};
					st_next.flush = 1'b1;
				end
				if (cif.op == gie_pkg::GIE_OP_INC) begin
					st_next.status = st_reg.flg;
					if (!cif.dst_f) begin
						st_next.work = st_reg.res;
					end
				end
			end
			default: st_next.ph = gie_pkg::PH_DECODE;
		endcase
		st_next.ph_first = (st_next.ph == gie_pkg::PH_DECODE);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_reg        <= '0;
			st_reg.ph     <= gie_pkg::PH_DECODE;
			st_reg.ph_first <= 1'b1;
			st_reg.ir     <= gie_pkg::NOP_WORD;
			st_reg.pc     <= gie_pkg::PC_RST;
			st_reg.work   <= gie_pkg::WORK_RST;
			st_reg.status <= gie_pkg::STATUS_RST;
			st_reg.bank   <= gie_pkg::BANK_RST;
			st_reg.index  <= gie_pkg::INDEX_RST;
			st_reg.run    <= gie_pkg::CTRL_RST[gie_pkg::CTRL_RUN_BIT];
			st_reg.ext    <= gie_pkg::CTRL_RST[gie_pkg::CTRL_EXT_BIT];
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o     = st_reg.rdat;
	assign wb_ack_o     = st_reg.ack;
	assign prog_addr    = st_reg.pc;
	assign data_addr    = st_reg.daddr;
	assign data_we      = st_reg.dwe;
	assign data_wr_data = st_reg.dwdat;
	assign work_reg_o   = st_reg.work;
	assign status_o     = st_reg.status;
	assign phase_start  = st_reg.ph_first;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_branch_pc_load: assert property (
		st_reg.ph == gie_pkg::PH_WRITE && cif.op == gie_pkg::GIE_OP_BRANCH && prog_data[15:12] == 4'hF
		|=> st_reg.pc == {$past(prog_data[11:0]), $past(st_reg.ir[7:0]), 1'b0})
		else $error("Branch did not load the literal into the program counter.");

	a_branch_keep_flags: assert property (
		st_reg.ph == gie_pkg::PH_READ && cif.op == gie_pkg::GIE_OP_BRANCH
		|=> $stable(st_reg.status) [*4])
		else $error("Branch changed the status flags.");

	a_branch_decode_hi: assert property (
		st_reg.ph == gie_pkg::PH_DECODE && st_reg.run && !st_reg.flush && prog_data[15:8] == 8'hEF
		|=> cif.op == gie_pkg::GIE_OP_BRANCH)
		else $error("First branch word was not recognised.");

	a_branch_bad_word: assert property (
		st_reg.ph == gie_pkg::PH_WRITE && cif.op == gie_pkg::GIE_OP_BRANCH && prog_data[15:12] != 4'hF
		|=> st_reg.pc == $past(st_reg.pc) && !st_reg.flush)
		else $error("Branch taken without a valid second word.");

	a_branch_empty_cycle: assert property (
		st_reg.ph == gie_pkg::PH_WRITE && cif.op == gie_pkg::GIE_OP_BRANCH && prog_data[15:12] == 4'hF
		|=> ##1 (!data_we && $stable(st_reg.work) && $stable(st_reg.pc)) [*4])
		else $error("Second branch cycle was not empty.");

	a_inc_write_back: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && cif.dst_f
		|=> data_we && data_wr_data == $past(data_rd_data) + 8'h01 ##1 !data_we)
		else $error("Increment write back wrong.");

	a_inc_to_work: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && !cif.dst_f
		|=> !data_we ##1 work_reg_o == $past(data_rd_data, 2) + 8'h01)
		else $error("Increment to working register wrong.");

	a_inc_wrap_flags: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && data_rd_data == 8'hFF
		|=> ##1 status_o[gie_pkg::ST_Z] && status_o[gie_pkg::ST_C] && !status_o[gie_pkg::ST_N])
		else $error("Wrap of increment set wrong flags.");

	a_bank_addr: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && cif.bank_sel
		|-> data_addr == {st_reg.bank, cif.faddr})
		else $error("Banked address wrong.");

	a_access_addr: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && !cif.bank_sel
		&& !(st_reg.ext && cif.faddr <= 8'h5F)
		|-> data_addr[7:0] == cif.faddr && data_addr[11:8] == (cif.faddr[7] ? 4'hF : 4'h0))
		else $error("Access bank address wrong.");

	a_index_addr: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && !cif.bank_sel
		&& st_reg.ext && cif.faddr <= 8'h5F
		|-> data_addr == st_reg.index + {4'h0, cif.faddr})
		else $error("Indexed offset address wrong.");

	a_write_phase: assert property (
		data_we |-> st_reg.ph == gie_pkg::PH_WRITE && $past(st_reg.ph, 3) == gie_pkg::PH_DECODE)
		else $error("Register write outside the write phase.");

	a_phase_marker: assert property (
		phase_start == (st_reg.ph == gie_pkg::PH_DECODE))
		else $error("Phase marker out of step with the decode phase.");

	a_branch_flush_cycle: assert property (
		st_reg.ph == gie_pkg::PH_WRITE && cif.op == gie_pkg::GIE_OP_BRANCH && prog_data[15:12] == 4'hF
		|=> st_reg.flush ##1 st_reg.ir == gie_pkg::NOP_WORD && st_reg.pc == $past(st_reg.pc))
		else $error("Second branch cycle fetched an instruction.");

	a_branch_lit_low: assert property (
		st_reg.ph == gie_pkg::PH_READ && cif.op == gie_pkg::GIE_OP_BRANCH
		|=> st_reg.lit_lo == $past(st_reg.ir[7:0]))
		else $error("Low literal byte not taken in the read phase.");

	a_branch_top_reach: assert property (
		st_reg.ph == gie_pkg::PH_WRITE && cif.op == gie_pkg::GIE_OP_BRANCH && prog_data == 16'hFFFF
		&& st_reg.lit_lo == 8'hFF
		|=> st_reg.pc == 21'h1F_FFFE)
		else $error("Largest branch literal did not reach the top of program space.");

	a_inc_sum_value: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC
		|=> st_reg.res == $past(data_rd_data) + 8'h01)
		else $error("Increment result wrong.");

	a_inc_sign_flags: assert property (
		st_reg.ph == gie_pkg::PH_PROCESS && cif.op == gie_pkg::GIE_OP_INC && data_rd_data == 8'h7F
		|=> ##1 status_o[gie_pkg::ST_OV] && status_o[gie_pkg::ST_N] && status_o[gie_pkg::ST_DC]
		&& !status_o[gie_pkg::ST_C] && !status_o[gie_pkg::ST_Z])
		else $error("Increment into the sign bit set wrong flags.");

	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Bus acknowledge lasted more than one cycle.");
endmodule

// ### dv/gie_mem_model.sv
// Program memory and data register file model facing the execution unit.
`timescale 1ns/1ps
module gie_mem_model (
	// Clock
	input  wire logic        ref_clk,
	// Program fetch
	input  wire logic [20:0] prog_addr,
	output logic      [15:0] prog_data,
	// Data register file
	input  wire logic [11:0] data_addr,
	output logic      [7:0]  data_rd_data,
	input  wire logic        data_we,
	input  wire logic [7:0]  data_wr_data
);
	logic [15:0] pmem [logic [20:0]];
	logic [7:0]  dmem [4096];

	// The clock is in the list so a reload while the address stands still is still seen.
	always @(prog_addr, ref_clk) begin
		prog_data = pmem.exists(prog_addr) ? pmem[prog_addr] : gie_pkg::NOP_WORD;
	end

	assign data_rd_data = dmem[data_addr];

	always @(posedge ref_clk) begin
		if (data_we) begin
			dmem[data_addr] <= data_wr_data;
		end
	end
endmodule

// ### dv/tb.sv
// Self-checking bench for the branch and increment execution unit.
`timescale 1ns/1ps
module tb;
	localparam int N = 20;
	localparam logic [7:0] OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
	localparam logic [7:0] CF [4] = '{8'h5F, 8'h60, 8'h7F, 8'h80};
	logic        ref_clk = 0;
	logic        reset = 1;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, q;
	logic [20:0] prog_addr;
	logic [15:0] prog_data;
	logic [11:0] data_addr;
	logic [7:0]  data_rd_data, data_wr_data, work_reg_o, w;
	logic        data_we, ack, phase_start;
	logic [4:0]  status_o, st;
	logic [7:0]  xmem [4096];
	int          err_total = 0;
	int          cmp_count = 0;
	int          ph = 0;

	gie_exec dut_u (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
		.data_rd_data(data_rd_data), .data_we(data_we), .data_wr_data(data_wr_data),
		.work_reg_o(work_reg_o), .status_o(status_o), .phase_start(phase_start));
	gie_mem_model mem_u (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_addr(data_addr), .data_rd_data(data_rd_data), .data_we(data_we),
		.data_wr_data(data_wr_data));

	always #5 ref_clk = ~ref_clk;

	task automatic test_done;
		$display("errors %0d, comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// One classic cycle; the slave's wait states are not assumed, only bounded.
	task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_en;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		chk({31'h0, ack}, 32'h1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	function automatic logic [12:0] inc_ref(input logic [7:0] v);
		logic [4:0] f;
		logic [7:0] r;
		r = v + 8'h01;
		f = '0;
		f[gie_pkg::ST_C] = (v == 8'hFF);
		f[gie_pkg::ST_DC] = (v[3:0] == 4'hF);
		f[gie_pkg::ST_Z] = (r == 8'h00);
		f[gie_pkg::ST_OV] = (v == 8'h7F);
		f[gie_pkg::ST_N] = r[7];
		return {f, r};
	endfunction

	// The data file may only be written in the third clock after a decode phase.
	always @(posedge ref_clk) begin
		ph <= phase_start ? 1 : ph + 1;
		if (data_we === 1'b1) chk(ph, 3);
	end

	initial begin
		#50_000;
		err_total++;
		test_done;
	end

	initial begin
		logic [19:0] t;
		logic [15:0] iw;
		logic [11:0] ea, ix;
		logic [12:0] r;
		logic [3:0]  bk;
		logic [20:0] tb_addr;
		void'($urandom(32'hcfc8));
		for (int ps = 0; ps < 2; ps++) begin
			reset <= 1'b1;
			repeat (8) @(posedge ref_clk);
			reset <= 1'b0;
			foreach (OFS[i]) begin
				wb(1'b0, OFS[i], 32'h0);
				chk(q, 32'h0);
			end
			bk = 4'($urandom);
			ix = 12'($urandom);
			wb(1'b1, gie_pkg::OFS_BANK, {28'h0, bk});
			wb(1'b1, gie_pkg::OFS_INDEX, {20'h0, ix});
			wb(1'b1, gie_pkg::OFS_WORK, 32'hFFFF_FFFF);
			wb(1'b0, gie_pkg::OFS_BANK, 32'h0);
			chk(q, {28'h0, bk});
			wb(1'b0, gie_pkg::OFS_INDEX, 32'h0);
			chk(q, {20'h0, ix});
			wb(1'b0, gie_pkg::OFS_WORK, 32'h0);
			chk(q, 32'h0);
			for (int a = 0; a < 4096; a++) begin
				case ($urandom % 4)
					0: xmem[a] = 8'hFF;
					1: xmem[a] = 8'h7F;
					2: xmem[a] = 8'h0F;
					default: xmem[a] = 8'($urandom);
				endcase
				mem_u.dmem[a] = xmem[a];
			end
			mem_u.pmem.delete();
			w = 8'h00;
			st = 5'h00;
			for (int i = 0; i < N; i++) begin
				iw = {gie_pkg::INC_OPCODE, 2'($urandom), 8'($urandom)};
				if (i < 4) iw[8:0] = {1'b0, CF[i]};
				// Address zero stays free: the top-of-space branch finds its second word there after the wrap.
				mem_u.pmem[21'(2 * i + 2)] = iw;
				ea = iw[8] ? {bk, iw[7:0]} : (ps == 1 && iw[7:0] <= 8'h5F) ? ix + iw[7:0] : {{4{iw[7]}}, iw[7:0]};
				r = inc_ref(xmem[ea]);
				st = r[12:8];
				if (iw[9]) xmem[ea] = r[7:0];
				else w = r[7:0];
			end
			t = (ps == 0) ? 20'hF_FFFF : 20'($urandom) | 20'h0_0100;
			tb_addr = {t, 1'b0};
			// A first branch word whose partner word lacks the marker nibble must not jump.
			mem_u.pmem[21'(2 * N + 2)] = {gie_pkg::BRANCH_W1_HI, 8'h00};
			mem_u.pmem[21'(2 * N + 4)] = 16'h0123;
			mem_u.pmem[21'(2 * N + 6)] = {gie_pkg::BRANCH_W1_HI, t[7:0]};
			mem_u.pmem[21'(2 * N + 8)] = {gie_pkg::BRANCH_W2_HI, t[19:8]};
			mem_u.pmem[tb_addr] = {gie_pkg::BRANCH_W1_HI, t[7:0]};
			mem_u.pmem[tb_addr + 21'h2] = {gie_pkg::BRANCH_W2_HI, t[19:8]};
			wb(1'b1, gie_pkg::OFS_CTRL, {30'h0, ps[0], 1'b1});
			for (int n = 0; n < 4 * (N + 8) && prog_addr !== tb_addr; n++) @(posedge ref_clk);
			repeat (16) @(posedge ref_clk);
			wb(1'b1, gie_pkg::OFS_CTRL, {30'h0, ps[0], 1'b0});
			repeat (8) @(posedge ref_clk);
			wb(1'b0, gie_pkg::OFS_PC, 32'h0);
			chk({31'h0, q === {11'h0, tb_addr} || q === {11'h0, tb_addr + 21'h2}}, 32'h1);
			wb(1'b0, gie_pkg::OFS_WORK, 32'h0);
			chk(q, {24'h0, w});
			chk({24'h0, work_reg_o}, {24'h0, w});
			wb(1'b0, gie_pkg::OFS_STATUS, 32'h0);
			chk(q, {27'h0, st});
			chk({27'h0, status_o}, {27'h0, st});
			for (int a = 0; a < 4096; a++) chk({24'h0, mem_u.dmem[a]}, {24'h0, xmem[a]});
		end
		test_done;
	end
endmodule
